//--- hw/osd_control.sv
// overlay control registers, working defaults, blink and colour output stage
`timescale 1ns/1ps
// How it works
// [R1] each vsync reloads working background, size and sub-mode from defaults, unless a defaults write or leading space plus return is in that cycle
// [R2] defaults register resets to 22h: blue box background, single dots
// [R3] working defaults change on defaults write or leading space plus return
// [R4] defaults bits 7..5 background red green blue; bit 4 reserved
// [R5] defaults bit 3 doubles dot height to two scan lines
// [R6] defaults bit 2 doubles dot width to two overlay clocks
// [R7] defaults bits 1..0 select superimpose, nw shadow, box, border
// [R8] split space latched per frame; second space always transparent
// [R9] control bit 6 enables meshing
// [R10] control bit 5: tv mode blanks on characters, frame mode on active lines
// [R11] control bit 4 selects horizontal sync input polarity
// [R12] control bit 3 selects vertical sync input polarity
// [R13] control bit 2 sets polarity of colour and fast blank outputs
// [R14] control bit 1 blink at vsync over 32 or 64, half duty
// [R15] control bit 0 clear holds colour and blank outputs inactive
// [R16] display starts four times origin scan lines after sync reference
// [R17] software keeps origin at one or more
// [R18] line counter advances per hsync, cleared by vsync
// [R19] normalized horizontal sync is always active high
// [R20] reserved register bits read zero and ignore writes
module osd_control #(
  parameter int LINE_W = 10
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // special function register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  // sync pins
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  // character renderer side
  input wire logic CHAR_PIXEL,
  input wire logic [2:0] CHAR_RGB,
  input wire logic SPACE2_PIXEL,
  input wire logic LEAD_SPACE_CR,
  input wire logic [7:0] LEAD_DEFAULTS,
  // working settings to the renderer
  output logic [2:0] WORK_BG_RGB,
  output logic WORK_VDOUBLE,
  output logic WORK_HDOUBLE,
  output osd_ctrl_pkg::submode_t WORK_SUBMODE,
  output logic SPLIT_SPACE_FIRST_EN,
  output logic MESH_EN,
  output logic BLINK_PHASE,
  // sync and display window
  output logic HSYNC_NORM,
  output logic VSYNC_NORM,
  output logic DISPLAY_START,
  output logic DISPLAY_REGION,
  // video outputs
  output logic RED,
  output logic GREEN,
  output logic BLUE,
  output logic FAST_BLANK
);
  import osd_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] defaults;
    logic [7:0] control;
    logic [7:0] origin;
    logic [7:0] rdata;
    logic [7:0] work;
    logic split_frame;
    logic [BLINK_CNT_W-1:0] vs_cnt;
    logic blink;
    logic red;
    logic green;
    logic blue;
    logic fb;
  } ctl_state_t;

  ctl_state_t state_ff;
  ctl_state_t nxt_state;

  sync_if sif ();

  logic wr_def;
  logic wr_ctl;
  logic wr_org;
  logic rd_def;
  logic enable;
  logic out_pol;
  logic frame_mode;
  logic active_line;
  logic fb_val;
  logic [2:0] rgb_val;

  // ---------------------------------------------------------------
  // sync path and vertical window
  // ---------------------------------------------------------------
  sync_normalizer u_sync (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .hsync_pin(HSYNC_IN),
    .vsync_pin(VSYNC_IN),
    .hs_pol(state_ff.control[CTL_HSYNC_POL]),
    .vs_pol(state_ff.control[CTL_VSYNC_POL]),
    .sif(sif)
  );

  vertical_origin_counter #(
    .LINE_W(LINE_W)
  ) u_vcnt (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .sif(sif),
    .origin(state_ff.origin[ORIGIN_W-1:0]),
    .start_pulse(DISPLAY_START),
    .region_active(DISPLAY_REGION)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign wr_def = SFR_WR && SFR_ADDR == ADDR_FRAME_DEFAULTS;
  assign wr_ctl = SFR_WR && SFR_ADDR == ADDR_CONTROL_ONE;
  assign wr_org = SFR_WR && SFR_ADDR == ADDR_VERTICAL_ORIGIN;
  assign rd_def = SFR_RD && SFR_ADDR == ADDR_FRAME_DEFAULTS;
  assign enable = state_ff.control[CTL_ENABLE];
  assign out_pol = state_ff.control[CTL_OUT_POL];
  assign frame_mode = state_ff.control[CTL_FRAME_MODE];
  assign active_line = !sif.hs_norm && !sif.vs_norm;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    // [R20] reserved bits masked on write
    if (wr_def) begin
      nxt_state.defaults = SFR_WDATA & MASK_FRAME_DEFAULTS;
    end
    if (wr_ctl) begin
      nxt_state.control = SFR_WDATA & MASK_CONTROL_ONE;
    end
    if (wr_org) begin
      nxt_state.origin = SFR_WDATA & MASK_VERTICAL_ORIGIN;
    end

    // read answer stands one cycle, unmapped reads zero
    nxt_state.rdata = READ_UNMAPPED;
    if (SFR_RD) begin
      case (SFR_ADDR)
        ADDR_FRAME_DEFAULTS: nxt_state.rdata = state_ff.defaults;
        ADDR_CONTROL_ONE: nxt_state.rdata = state_ff.control;
        ADDR_VERTICAL_ORIGIN: nxt_state.rdata = state_ff.origin;
        default: nxt_state.rdata = READ_UNMAPPED;
      endcase
    end

    // [R1] vsync reload of working defaults
    if (sif.vs_lead) begin
      nxt_state.work = state_ff.defaults;
    end
    // [R3] leading space and return code load
    if (LEAD_SPACE_CR) begin
      nxt_state.work = LEAD_DEFAULTS & MASK_FRAME_DEFAULTS;
    end
    // [R3] software write takes effect at once, winning over both
    if (wr_def) begin
      nxt_state.work = SFR_WDATA & MASK_FRAME_DEFAULTS;
    end

    // [R8] split space sampled once per frame
    if (sif.vs_lead) begin
      nxt_state.split_frame = state_ff.control[CTL_SPLIT];
      nxt_state.vs_cnt = state_ff.vs_cnt + BLINK_CNT_W'(1);
    end
    // [R14] blink from frame counter, half duty by construction
    nxt_state.blink = nxt_state.control[CTL_BLINK_RATE] ?
      nxt_state.vs_cnt[BLINK_BIT_SLOW] : nxt_state.vs_cnt[BLINK_BIT_FAST];

    // [R10] fast blank source by background mode; [R8] second space transparent
    fb_val = !SPACE2_PIXEL && (frame_mode ? active_line : CHAR_PIXEL);
    rgb_val = 3'h0;
    if (fb_val) begin
      rgb_val = CHAR_PIXEL ? CHAR_RGB : state_ff.work[DEF_BG_HI:DEF_BG_LO];
    end
    // [R15] disabled overlay idles at inactive level
    if (!enable) begin
      fb_val = 1'b0;
      rgb_val = 3'h0;
    end
    // [R13] common output polarity
    nxt_state.red = rgb_val[2] ^ ~out_pol;
    nxt_state.green = rgb_val[1] ^ ~out_pol;
    nxt_state.blue = rgb_val[0] ^ ~out_pol;
    nxt_state.fb = fb_val ^ ~out_pol;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= '0;
      // [R2] defaults reset value
      state_ff.defaults <= RST_FRAME_DEFAULTS;
      state_ff.work <= RST_FRAME_DEFAULTS;
      state_ff.control <= RST_CONTROL_ONE;
      state_ff.origin <= RST_VERTICAL_ORIGIN;
      // outputs idle inactive for the reset polarity (active low)
      state_ff.red <= 1'b1;
      state_ff.green <= 1'b1;
      state_ff.blue <= 1'b1;
      state_ff.fb <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SFR_RDATA = state_ff.rdata;
  // [R4] background colour field
  assign WORK_BG_RGB = state_ff.work[DEF_BG_HI:DEF_BG_LO];
  // [R5] dot height doubling
  assign WORK_VDOUBLE = state_ff.work[DEF_VDOUBLE];
  // [R6] dot width doubling
  assign WORK_HDOUBLE = state_ff.work[DEF_HDOUBLE];
  // [R7] sub-mode field
  assign WORK_SUBMODE = submode_t'(state_ff.work[DEF_SUBMODE_HI:DEF_SUBMODE_LO]);
  assign SPLIT_SPACE_FIRST_EN = state_ff.split_frame;
  // [R9] meshing enable
  assign MESH_EN = state_ff.control[CTL_MESH];
  assign BLINK_PHASE = state_ff.blink;
  assign HSYNC_NORM = sif.hs_norm;
  assign VSYNC_NORM = sif.vs_norm;
  assign RED = state_ff.red;
  assign GREEN = state_ff.green;
  assign BLUE = state_ff.blue;
  assign FAST_BLANK = state_ff.fb;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_def_read;
    rd_def ##1 1'b1;
  endsequence

  a_vsync_reload: assert property (sif.vs_lead && !wr_def && !LEAD_SPACE_CR |=> // [R1]
    state_ff.work == $past(state_ff.defaults)) else $error("vsync reload missed");
  a_sw_write_work: assert property (wr_def |=> // [R3]
    state_ff.work == ($past(SFR_WDATA) & MASK_FRAME_DEFAULTS))
    else $error("defaults write not applied");
  a_reserved_zero: assert property (!state_ff.defaults[DEF_RESERVED] // [R20]
    && state_ff.origin[7:6] == 2'h0) else $error("reserved bit set");
  a_def_readback: assert property (s_def_read |-> // [R4]
    SFR_RDATA == $past(state_ff.defaults)) else $error("defaults readback wrong");
  a_disabled_idle: assert property (!$past(enable) |-> // [R15]
    {RED, GREEN, BLUE, FAST_BLANK} == {4{~$past(out_pol)}}) else $error("not idle");
  a_frame_blank: assert property ($past(enable && frame_mode && !SPACE2_PIXEL) |-> // [R10]
    FAST_BLANK == ($past(active_line) ~^ $past(out_pol))) else $error("frame blank wrong");
  a_tv_blank: assert property ($past(enable && !frame_mode) |-> // [R10]
    FAST_BLANK == (($past(CHAR_PIXEL) && !$past(SPACE2_PIXEL)) ~^ $past(out_pol)))
    else $error("tv blank wrong");
  a_blink_on_frame: assert property ($changed(state_ff.blink) |-> // [R14]
    $past(sif.vs_lead) || $past(wr_ctl)) else $error("blink moved off frame");
  a_split_frame: assert property ($changed(state_ff.split_frame) |-> // [R8]
    $past(sif.vs_lead)) else $error("split changed mid-frame");
endmodule // osd_control

//--- shared/osd_ctrl_pkg.sv
// constants, field positions and types for the overlay control block
package osd_ctrl_pkg;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAME_DEFAULTS = 8'h9c;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'hc1;
  localparam logic [7:0] ADDR_VERTICAL_ORIGIN = 8'hc2;
  // ---------------------------------------------------------------
  // values after reset and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FRAME_DEFAULTS = 8'h22;
  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_VERTICAL_ORIGIN = 8'h01;
  localparam logic [7:0] MASK_FRAME_DEFAULTS = 8'hef;
  localparam logic [7:0] MASK_CONTROL_ONE = 8'hff;
  localparam logic [7:0] MASK_VERTICAL_ORIGIN = 8'h3f;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // ---------------------------------------------------------------
  // frame defaults fields
  // ---------------------------------------------------------------
  localparam int DEF_BG_HI = 7;
  localparam int DEF_BG_LO = 5;
  localparam int DEF_RESERVED = 4;
  localparam int DEF_VDOUBLE = 3;
  localparam int DEF_HDOUBLE = 2;
  localparam int DEF_SUBMODE_HI = 1;
  localparam int DEF_SUBMODE_LO = 0;
  // ---------------------------------------------------------------
  // control one fields
  // ---------------------------------------------------------------
  localparam int CTL_SPLIT = 7;
  localparam int CTL_MESH = 6;
  localparam int CTL_FRAME_MODE = 5;
  localparam int CTL_HSYNC_POL = 4;
  localparam int CTL_VSYNC_POL = 3;
  localparam int CTL_OUT_POL = 2;
  localparam int CTL_BLINK_RATE = 1;
  localparam int CTL_ENABLE = 0;
  // ---------------------------------------------------------------
  // vertical origin and blink
  // ---------------------------------------------------------------
  localparam int ORIGIN_W = 6;
  localparam int LINES_PER_STEP = 4;
  localparam int BLINK_CNT_W = 6;
  localparam int BLINK_BIT_SLOW = 5;
  localparam int BLINK_BIT_FAST = 4;
  typedef enum logic [1:0] {
    SUB_SUPERIMPOSE,
    SUB_NW_SHADOW,
    SUB_BOX,
    SUB_BORDER
  } submode_t;
endpackage

//--- shared/sync_if.sv
// normalized sync levels and leading-edge pulses between modules
`timescale 1ns/1ps
interface sync_if;
  logic hs_norm;
  logic vs_norm;
  logic hs_lead;
  logic vs_lead;
  modport source (output hs_norm, output vs_norm, output hs_lead, output vs_lead);
  modport sink (input hs_norm, input vs_norm, input hs_lead, input vs_lead);
endinterface // sync_if

//--- hw/sync_normalizer.sv
// sync pin synchronisers, polarity selection and leading-edge detection
`timescale 1ns/1ps
module sync_normalizer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and polarity
  input wire logic hsync_pin,
  input wire logic vsync_pin,
  input wire logic hs_pol,
  input wire logic vs_pol,
  // normalized sync
  sync_if.source sif
);
  import osd_ctrl_pkg::*;

  // idle pin level for the polarity that control resets to
  localparam logic HS_IDLE = ~RST_CONTROL_ONE[CTL_HSYNC_POL];
  localparam logic VS_IDLE = ~RST_CONTROL_ONE[CTL_VSYNC_POL];

  typedef struct packed {
    logic hs_meta;
    logic hs_sync;
    logic vs_meta;
    logic vs_sync;
    logic hs_norm;
    logic vs_norm;
    logic hs_lead;
    logic vs_lead;
  } norm_state_t;

  norm_state_t state_ff;
  norm_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.hs_meta = hsync_pin;
    nxt_state.hs_sync = state_ff.hs_meta;
    nxt_state.vs_meta = vsync_pin;
    nxt_state.vs_sync = state_ff.vs_meta;
    // [R11] [R19] hsync polarity select, active high after
    nxt_state.hs_norm = state_ff.hs_sync ^ ~hs_pol;
    // [R12] vsync polarity select
    nxt_state.vs_norm = state_ff.vs_sync ^ ~vs_pol;
    // a polarity change mid-line can fake one edge; harmless, next sync realigns
    nxt_state.hs_lead = nxt_state.hs_norm & ~state_ff.hs_norm;
    nxt_state.vs_lead = nxt_state.vs_norm & ~state_ff.vs_norm;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // start at the idle pin level, else release fakes a sync lead
      state_ff <= '0;
      state_ff.hs_meta <= HS_IDLE;
      state_ff.hs_sync <= HS_IDLE;
      state_ff.vs_meta <= VS_IDLE;
      state_ff.vs_sync <= VS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sif.hs_norm = state_ff.hs_norm;
  assign sif.vs_norm = state_ff.vs_norm;
  assign sif.hs_lead = state_ff.hs_lead;
  assign sif.vs_lead = state_ff.vs_lead;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hs_active_high: assert property (state_ff.hs_lead |-> state_ff.hs_norm // [R19]
    && !$past(state_ff.hs_norm)) else $error("hsync lead without rising normalized level");
  a_hs_pol_follow: assert property ($stable(hs_pol) [*3] |-> // [R11]
    state_ff.hs_norm == ($past(hsync_pin, 3) ^ ~hs_pol)) else $error("hsync polarity wrong");
endmodule // sync_normalizer

//--- hw/vertical_origin_counter.sv
// scan line counter from vertical sync and display start detection
`timescale 1ns/1ps
module vertical_origin_counter #(
  parameter int LINE_W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sync and origin
  sync_if.sink sif,
  input wire logic [osd_ctrl_pkg::ORIGIN_W-1:0] origin,
  // display start
  output logic start_pulse,
  output logic region_active
);
  import osd_ctrl_pkg::*;

  typedef struct packed {
    logic [LINE_W-1:0] line_cnt;
    logic start;
    logic region;
  } vcnt_state_t;

  vcnt_state_t state_ff;
  vcnt_state_t nxt_state;
  logic [LINE_W-1:0] target;
  logic [LINE_W-1:0] line_inc;

  assign target = LINE_W'(origin) * LINE_W'(LINES_PER_STEP);
  assign line_inc = state_ff.line_cnt + LINE_W'(1);

  always_comb begin
    nxt_state = state_ff;
    nxt_state.start = 1'b0;
    // [R18] clear on vsync
    if (sif.vs_lead) begin
      nxt_state.line_cnt = '0;
      nxt_state.region = 1'b0;
    end else if (sif.hs_lead) begin
      // saturate so a missing vsync never wraps into a false start
      if (line_inc != '0) begin
        nxt_state.line_cnt = line_inc;
      end
      // [R16] start after four lines per step; [R17] zero never starts
      if (origin != '0 && line_inc == target && !state_ff.region) begin
        nxt_state.start = 1'b1;
        nxt_state.region = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign start_pulse = state_ff.start;
  assign region_active = state_ff.region;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_line_count: assert property (state_ff.start |-> // [R16]
    state_ff.line_cnt == LINE_W'($past(origin)) * LINE_W'(LINES_PER_STEP))
    else $error("display start on wrong line");
  a_vsync_clear: assert property (sif.vs_lead |=> state_ff.line_cnt == '0 // [R18]
    && !state_ff.region) else $error("vsync did not clear line counter");
endmodule // vertical_origin_counter

//--- verif/sync_source_model.sv
// sync source model: line and frame timing on the two sync pins
`timescale 1ns/1ps
module sync_source_model #(
  parameter int LINE_CYC = 12,
  parameter int FRAME_LINES = 40
) (
  // clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic hs_pol,
  input wire logic vs_pol,
  // sync pins
  output logic hsync,
  output logic vsync
);
  int pix = 0;
  int line = 0;
  logic hs_act;
  logic vs_act;
  always @(posedge clk) begin
    if (!run) begin
      pix <= 0;
      line <= 0;
    end else if (pix == LINE_CYC - 1) begin
      pix <= 0;
      line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
    end else begin
      pix <= pix + 1;
    end
  end
  // vsync opens mid line so its lead never meets an hsync lead
  assign hs_act = run && (pix < 3);
  assign vs_act = run && ((line == 0 && pix >= 6) || line == 1 || (line == 2 && pix < 6));
  // pins stay inactive while stopped, at the level the polarity implies
  assign #1 hsync = hs_act ~^ hs_pol;
  assign #1 vsync = vs_act ~^ vs_pol;
endmodule // sync_source_model

//--- verif/testbench.sv
// self-checking bench for the overlay control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  import osd_ctrl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cp = 1'b0, sp2 = 1'b0, lead = 1'b0;
  logic run = 1'b0, rnd_on = 1'b0, chk_sync = 1'b0, chk_vid = 1'b0, split_exp, hs_q, vs_q;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lead_def = 8'h00, ctl_sh = 8'h00, def_sh = 8'h22;
  logic [7:0] rv, org, hl, fcnt, n0, rdata, p_ctl;
  logic [2:0] crgb = 3'h0, p_rgb, p_bg, bg, hh, vh;
  logic p_cp, p_sp2, p_hn, p_vn, vdbl, hdbl, split, mesh, blink, hs_n, vs_n, dstart, dreg;
  logic red, green, blue, fb, hs_in, vs_in;
  logic [3:0] ev;
  logic [31:0] seed, vseed;
  submode_t sub;
  int cyc = 0, n_mismatch = 0, samples_checked = 0;
  logic [7:0] ra [4] = '{ADDR_FRAME_DEFAULTS, ADDR_CONTROL_ONE, ADDR_VERTICAL_ORIGIN, 8'h9d};
  logic [7:0] rs [4] = '{RST_FRAME_DEFAULTS, RST_CONTROL_ONE, RST_VERTICAL_ORIGIN, READ_UNMAPPED};
  logic [7:0] rm [4] = '{MASK_FRAME_DEFAULTS, MASK_CONTROL_ONE, MASK_VERTICAL_ORIGIN, 8'h00};
  wire logic hs_act = hs_in ~^ ctl_sh[CTL_HSYNC_POL];
  wire logic vs_act = vs_in ~^ ctl_sh[CTL_VSYNC_POL];

  osd_control u_osd_control (.CORE_CLK(clk), .RESET_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr),
    .SFR_WDATA(wdata), .SFR_RD(rd), .SFR_RDATA(rdata), .HSYNC_IN(hs_in), .VSYNC_IN(vs_in),
    .CHAR_PIXEL(cp), .CHAR_RGB(crgb), .SPACE2_PIXEL(sp2), .LEAD_SPACE_CR(lead),
    .LEAD_DEFAULTS(lead_def), .WORK_BG_RGB(bg), .WORK_VDOUBLE(vdbl), .WORK_HDOUBLE(hdbl),
    .WORK_SUBMODE(sub), .SPLIT_SPACE_FIRST_EN(split), .MESH_EN(mesh), .BLINK_PHASE(blink),
    .HSYNC_NORM(hs_n), .VSYNC_NORM(vs_n), .DISPLAY_START(dstart), .DISPLAY_REGION(dreg),
    .RED(red), .GREEN(green), .BLUE(blue), .FAST_BLANK(fb));
  sync_source_model u_sync_source_model (.clk(clk), .run(run), .hs_pol(ctl_sh[CTL_HSYNC_POL]),
    .vs_pol(ctl_sh[CTL_VSYNC_POL]), .hsync(hs_in), .vsync(vs_in));

  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [3:0] exp_vid(input logic [7:0] c, input logic p,
    input logic [2:0] rgb, input logic s2, input logic hn, input logic vn, input logic [2:0] b);
    logic f;
    logic [2:0] col;
    f = c[CTL_ENABLE] & ~s2 & (c[CTL_FRAME_MODE] ? (~hn & ~vn) : p);
    col = f ? (p ? rgb : b) : 3'h0;
    return c[CTL_OUT_POL] ? {col, f} : ~{col, f};
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
    if (a == ADDR_CONTROL_ONE) ctl_sh = d;
    if (a == ADDR_FRAME_DEFAULTS) def_sh = d & MASK_FRAME_DEFAULTS;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic chk_work(input logic [7:0] v);
    `CHK("work bg", v[7:5], bg)
    `CHK("work vdouble", v[3], vdbl)
    `CHK("work hdouble", v[2], hdbl)
    `CHK("work submode", v[1:0], sub)
  endtask
  task automatic wr_def(input logic [7:0] d);
    sfr_wr(ADDR_FRAME_DEFAULTS, d);
    chk_work(d & MASK_FRAME_DEFAULTS);
  endtask
  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, monitors and random pixel stimulus
  // ---------------------------------------------------------------
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      n_mismatch++;
      results();
    end
  end
  always @(posedge clk) begin
    {p_cp, p_sp2, p_rgb, p_bg, p_hn, p_vn, p_ctl} <= {cp, sp2, crgb, bg, hs_n, vs_n, ctl_sh};
    hh <= {hh[1:0], hs_in};
    vh <= {vh[1:0], vs_in};
    hs_q <= hs_act;
    vs_q <= vs_act;
    if (!rst_n) begin
      fcnt <= 8'h00;
      hl <= 8'h00;
    end else if (vs_act & ~vs_q) begin
      fcnt <= fcnt + 8'h01;
      hl <= 8'h00;
    end else if (hs_act & ~hs_q) begin
      hl <= hl + 8'h01;
    end
  end
  always @(negedge clk) begin
    if (chk_sync) begin
      `CHK("hsync norm", hh[2] ~^ ctl_sh[CTL_HSYNC_POL], hs_n)
      `CHK("vsync norm", vh[2] ~^ ctl_sh[CTL_VSYNC_POL], vs_n)
    end
    if (chk_vid) begin
      ev = exp_vid(p_ctl, p_cp, p_rgb, p_sp2, p_hn, p_vn, p_bg);
      `CHK("video", ev, {red, green, blue, fb})
    end
  end
  // separate state so the pixel stream does not race the main sequence
  always @(posedge clk) begin
    if (rnd_on) begin
      #1;
      vseed = xs(vseed);
      {cp, crgb} = vseed[3:0];
      sp2 = vseed[4] & vseed[5];
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hba2f0530;
    vseed = ~seed;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (ra[i]) begin
      sfr_rd(ra[i], rv);
      `CHK("reset value", rs[i], rv)
      sfr_wr(ra[i], 8'hff);
      sfr_rd(ra[i], rv);
      `CHK("write mask", rm[i], rv)
    end
    // both sync inputs active high, then a reset in mid-run
    sfr_wr(ADDR_CONTROL_ONE, 8'h19);
    repeat (8) @(posedge clk);
    #1 run = 1'b1;
    repeat (6) @(posedge clk);
    chk_sync = 1'b1;
    repeat (960) @(posedge clk);
    chk_sync = 1'b0;
    #1 run = 1'b0;
    rst_n = 1'b0;
    ctl_sh = RST_CONTROL_ONE;
    def_sh = RST_FRAME_DEFAULTS;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rnd(rv);
      wr_def({rv[7:2], i[1:0]});
    end
    rnd(lead_def);
    @(posedge clk) #1;
    lead = 1'b1;
    @(posedge clk) #1;
    lead = 1'b0;
    chk_work(lead_def & MASK_FRAME_DEFAULTS);
    sfr_wr(ADDR_CONTROL_ONE, 8'h01);
    rnd_on = 1'b1;
    run = 1'b1;
    chk_sync = 1'b1;
    chk_vid = 1'b1;
    for (int f = 0; f < 70; f++) begin
      n0 = fcnt;
      for (int k = 0; k < 600 && fcnt == n0; k++) @(posedge clk);
      split_exp = ctl_sh[CTL_SPLIT];
      rnd(rv);
      org = rv % 8'h09 + 8'h01;
      sfr_wr(ADDR_VERTICAL_ORIGIN, org);
      for (int k = 0; k < 600 && dstart !== 1'b1; k++) @(negedge clk);
      `CHK("start line", org << 2, hl)
      `CHK("region", 1'b1, dreg)
      chk_work(def_sh);
      `CHK("split frame", split_exp, split)
      `CHK("blink", ctl_sh[CTL_BLINK_RATE] ? fcnt[5] : fcnt[4], blink)
      @(negedge clk);
      `CHK("start pulse", 1'b0, dstart)
      rnd(rv);
      sfr_wr(ADDR_CONTROL_ONE, {rv[7:5], 2'b00, rv[2:0]});
      `CHK("split hold", split_exp, split)
      `CHK("mesh", ctl_sh[CTL_MESH], mesh)
      rnd(rv);
      wr_def(rv);
    end
    // origin zero must never open the window, over the rest of this frame and one whole frame
    sfr_wr(ADDR_VERTICAL_ORIGIN, 8'h00);
    repeat (2) begin
      n0 = fcnt;
      for (int k = 0; k < 600 && fcnt == n0; k++) begin
        @(negedge clk);
        `CHK("no start", 1'b0, dstart)
      end
    end
    `CHK("no region", 1'b0, dreg)
    results();
  end
endmodule // testbench
